/* logic/des_security_engine.sv */
// des_security_engine: block cipher engine with key store behind a byte register port
// assumes a host on ref_clk_i issuing one-cycle strobes; base switches are async pins
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - one 64-bit block per run, 56-bit key
// - a block takes 320 engine clocks
// - block or cipher feedback, host selects
// - key load targets active or major key
// - deciphered wrapped key becomes active key
// - restore copies major key into active
// - show active key parity status
// - busy status, pollable or as interrupt
// - result read bytewise, each within 500 ns
// - register window at switch-selected base address
module des_security_engine (
  input  wire logic        ref_clk_i,     // engine clock
  input  wire logic        rst_n_i,       // sync reset, active low
  input  wire logic [15:0] addr_i,        // host address
  input  wire logic [7:0]  wdata_i,       // host write data
  input  wire logic        wr_i,          // write strobe
  input  wire logic        rd_i,          // read strobe
  input  wire logic [15:0] base_sw_i,     // base address switches
  output logic      [7:0]  rdata_o,       // read data, cycle after strobe
  output logic             irq_o,         // level interrupt
  output logic             busy_o,        // algorithm running
  output logic             key_par_ok_o   // active key parity good
);
  import des_pkg::*;

  // all engine state in one record
  typedef struct packed {
    logic [15:0] sw1;      // switch sync, first stage
    logic [15:0] sw2;      // second stage
    logic [15:0] sw3;      // third stage
    logic [15:0] base;     // agreed base address
    logic [63:0] din;      // input block
    logic [63:0] dout;     // result block
    logic [63:0] iv;       // feedback register
    logic [63:0] stage;    // staged key
    logic [63:0] act_key;  // key in use
    logic [63:0] maj_key;  // stored major key
    logic [31:0] l;        // left half
    logic [31:0] r;        // right half
    logic [27:0] c;        // key schedule, upper half
    logic [27:0] d;        // key schedule, lower half
    logic [3:0]  rnd;      // round index
    logic [4:0]  sub;      // cycle within round
    logic        dec;      // ctrl: decipher
    logic        cfb;      // ctrl: feedback mode
    logic        run_dec;  // schedule direction of this run
    job_t        job;      // what to do with the result
    eng_state_t  st;       // sequencer state
    logic [1:0]  pend;     // sticky events
    logic [1:0]  mask;     // event enables
    logic [7:0]  rdata;    // read answer
    logic        irq;      // interrupt flop
    logic        busy;     // busy flop
    logic        par_ok;   // parity flop
  } eng_regs_t;

  eng_regs_t   q;         // registered state
  eng_regs_t   n;         // next state
  logic        hit;       // address inside our window
  logic [4:0]  ofs;       // offset within window
  logic        one_sh;    // rotate by one this round
  logic        no_sh;     // first decipher round keeps the key
  logic [27:0] c_sh;      // rotated c
  logic [27:0] d_sh;      // rotated d
  logic [63:0] rk64;      // round key, low 48 used
  logic [1:0]  clr;       // write-one-to-clear bits
  logic [1:0]  set_ev;    // events this cycle
  logic        start;     // launch a run
  logic [63:0] blk;       // block to launch with
  logic [63:0] ip;        // permuted launch block
  logic [63:0] pc;        // permuted launch key
  logic [63:0] res;       // finished block
  logic [7:0]  stat;      // status byte

  des_round_if rif ();

  des_round u_round (
    .rif (rif.round)
  );

  // rotate a schedule half; right rotation walks the schedule backwards
  function automatic logic [27:0] rot28(input logic [27:0] x, input logic left, input logic one);
    if (!left)
      return one ? {x[0], x[27:1]} : {x[1:0], x[27:2]};
    return one ? {x[26:0], x[27]} : {x[25:0], x[27:26]};
  endfunction

  assign hit = (addr_i[15:5] == q.base[15:5]);
  assign ofs = addr_i[4:0];

  // round key: decipher starts from the last key, which equals the loaded one
  assign one_sh  = q.run_dec ? ROT_ONE_DEC[q.rnd] : ROT_ONE_ENC[q.rnd];
  assign no_sh   = q.run_dec && (q.rnd == 4'h0);
  assign c_sh    = no_sh ? q.c : rot28(q.c, !q.run_dec, one_sh);
  assign d_sh    = no_sh ? q.d : rot28(q.d, !q.run_dec, one_sh);
  assign rk64    = permute({8'h00, c_sh, d_sh}, {128'h0, PC2_TAB}, 48, 56);
  assign rif.r_half = q.r;
  assign rif.subkey = rk64[47:0];

  // next-state logic for the whole engine
  always_comb
  begin
    n      = q;
    clr    = 2'h0;
    set_ev = 2'h0;
    start  = 1'b0;
    blk    = q.din;
    ip     = '0;
    pc     = '0;
    res    = '0;
    stat   = 8'h00;

    // switches: three stages, take a value once the last two agree
    n.sw1 = base_sw_i;
    n.sw2 = q.sw1;
    n.sw3 = q.sw2;
    if (q.sw2 == q.sw3)
      n.base = q.sw3;

    // parity is watched every cycle so it follows any key change
    n.par_ok = odd_parity_ok(q.act_key);

    // reads answer next cycle, zero outside the window or on holes
    n.rdata = 8'h00;
    stat[STAT_BUSY_BIT] = q.busy;
    stat[STAT_PAR_BIT]  = q.par_ok;
    if (rd_i && hit)
    begin
      if (ofs[4:3] == OFS_DATA[4:3])
        n.rdata = get_byte(q.dout, ofs[2:0]);
      else if (ofs[4:3] == OFS_IV[4:3])
        n.rdata = get_byte(q.iv, ofs[2:0]);
      else if (ofs == OFS_CTRL)
        n.rdata = {6'h00, q.cfb, q.dec};
      else if (ofs == OFS_STAT)
        n.rdata = stat;
      else if (ofs == OFS_INT)
        n.rdata = {6'h00, q.pend};
      else if (ofs == OFS_MASK)
        n.rdata = {6'h00, q.mask};
      // key bytes read as zero: keys never leave the engine
    end

    // writes
    if (wr_i && hit)
    begin
      if (ofs[4:3] == OFS_DATA[4:3])
        n.din = set_byte(q.din, ofs[2:0], wdata_i);
      else if (ofs[4:3] == OFS_KEY[4:3])
        n.stage = set_byte(q.stage, ofs[2:0], wdata_i);
      else if (ofs[4:3] == OFS_IV[4:3])
        n.iv = set_byte(q.iv, ofs[2:0], wdata_i);
      else if (ofs == OFS_CTRL)
      begin
        n.dec = wdata_i[CTRL_DEC_BIT];
        n.cfb = wdata_i[CTRL_CFB_BIT];
      end
      else if (ofs == OFS_INT)
        clr = wdata_i[1:0];
      else if (ofs == OFS_MASK)
        n.mask = wdata_i[1:0];
      else if (ofs == OFS_CMD)
      begin
        // commands during a run would corrupt the key in use
        if (q.st == ST_RUN)
          set_ev[INT_REFUSE_BIT] = 1'b1;
        else
        begin
          case (wdata_i)
            CMD_START:
            begin
              start     = 1'b1;
              blk       = q.cfb ? q.iv : q.din;
              n.run_dec = q.cfb ? 1'b0 : q.dec;  // feedback always enciphers
              n.job     = !q.cfb ? JOB_BLOCK : (q.dec ? JOB_CFB_DEC : JOB_CFB_ENC);
            end
            CMD_UNWRAP:
            begin
              start     = 1'b1;
              blk       = q.stage;
              n.run_dec = 1'b1;
              n.job     = JOB_UNWRAP;
            end
            CMD_LOAD_ACT: n.act_key = q.stage;
            CMD_LOAD_MAJ: n.maj_key = q.stage;
            CMD_RESTORE:  n.act_key = q.maj_key;
            default:      set_ev[INT_REFUSE_BIT] = 1'b1;
          endcase
        end
      end
    end

    // launch: permute block into halves and key into schedule
    if (start)
    begin
      ip    = permute(blk, IP_TAB, 64, 64);
      pc    = permute(q.act_key, {64'h0, PC1_TAB}, 56, 64);
      n.l   = ip[63:32];
      n.r   = ip[31:0];
      n.c   = pc[55:28];  // parity bits dropped, 56 remain
      n.d   = pc[27:0];
      n.rnd = 4'h0;
      n.sub = 5'h00;
      n.st  = ST_RUN;
    end

    // run: one round every CYC_PER_ROUND cycles, sixteen rounds in all
    case (q.st)
      ST_RUN:
      begin
        if (q.sub == 5'(CYC_PER_ROUND - 1))
        begin
          n.sub = 5'h00;
          n.c   = c_sh;
          n.d   = d_sh;
          n.l   = q.r;
          n.r   = q.l ^ rif.f_out;
          n.rnd = q.rnd + 4'h1;
          if (q.rnd == 4'(ROUNDS - 1))
          begin
            // last round: halves swapped back before the final permutation
            res  = ip_inverse({q.l ^ rif.f_out, q.r});
            n.st = ST_IDLE;
            set_ev[INT_DONE_BIT] = 1'b1;
            case (q.job)
              JOB_UNWRAP:  n.act_key = res;
              JOB_CFB_ENC:
              begin
                n.dout = q.din ^ res;
                n.iv   = q.din ^ res;  // ciphertext feeds back
              end
              JOB_CFB_DEC:
              begin
                n.dout = q.din ^ res;
                n.iv   = q.din;
              end
              default:     n.dout = res;
            endcase
          end
        end
        else
          n.sub = q.sub + 5'h01;
      end
      ST_IDLE: ;
      default: n.st = ST_IDLE;
    endcase

    // sticky events: a set in the clearing cycle survives
    n.pend = (q.pend & ~clr) | set_ev;
    n.irq  = |(n.pend & n.mask);
    n.busy = (n.st == ST_RUN);
  end

  // single state register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q      <= '0;
      q.base <= BASE_RST;
      q.mask <= MASK_RST;
      q.st   <= ST_IDLE;
    end
    else
      q <= n;
  end

  assign rdata_o      = q.rdata;
  assign irq_o        = q.irq;
  assign busy_o       = q.busy;
  assign key_par_ok_o = q.par_ok;

  // checks
  logic [8:0]  run_len;    // busy cycles of the current run
  logic        stage_par;  // parity of the staged key
  logic [7:0]  data_byte;  // result byte under the address
  assign stage_par = odd_parity_ok(q.stage);
  assign data_byte = get_byte(q.dout, ofs[2:0]);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      run_len <= 9'h000;
    else if (busy_o)
      run_len <= run_len + 9'h001;
    else
      run_len <= 9'h000;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd(logic [7:0] c);
    wr_i && hit && (ofs == OFS_CMD) && (wdata_i == c) && (q.st == ST_IDLE);
  endsequence

  property p_run_len;
    $fell(busy_o) |-> (run_len == 9'(ALGO_CYCLES));
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("run length differs from block time");

  property p_rounds;
    $fell(busy_o) |-> ($past(q.rnd) == 4'hF);
  endproperty
  a_rounds: assert property (p_rounds)
    else $error("run ended before sixteen rounds");

  property p_cfb_feedback;
    ($fell(busy_o) && (q.job == JOB_CFB_ENC)) |-> (q.iv == q.dout);
  endproperty
  a_cfb_feedback: assert property (p_cfb_feedback)
    else $error("feedback register not loaded with ciphertext");

  property p_load_act;
    s_cmd(CMD_LOAD_ACT) |=> (q.act_key == $past(q.stage)) ##1 (key_par_ok_o == $past(stage_par, 2));
  endproperty
  a_load_act: assert property (p_load_act)
    else $error("active key load or its parity wrong");

  property p_load_maj;
    s_cmd(CMD_LOAD_MAJ) |=> (q.maj_key == $past(q.stage)) && $stable(q.act_key);
  endproperty
  a_load_maj: assert property (p_load_maj)
    else $error("major key load wrong");

  property p_unwrap;
    s_cmd(CMD_UNWRAP) |=> (busy_o && q.job == JOB_UNWRAP) ##[320:320] (!busy_o && q.pend[INT_DONE_BIT]);
  endproperty
  a_unwrap: assert property (p_unwrap)
    else $error("key unwrap did not finish on time");

  property p_restore;
    s_cmd(CMD_RESTORE) |=> (q.act_key == $past(q.maj_key));
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore did not copy major key");

  property p_parity;
    $changed(q.act_key) |=> (key_par_ok_o == odd_parity_ok($past(q.act_key)));
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity status does not follow key");

  property p_done_irq;
    ($fell(busy_o) && q.mask[INT_DONE_BIT]) |-> irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("done event without interrupt");

  property p_read_byte;
    (rd_i && hit && (ofs[4:3] == OFS_DATA[4:3])) |=> (rdata_o == $past(data_byte));
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("result byte not returned next cycle");

  property p_off_base;
    (rd_i && !hit) |=> (rdata_o == 8'h00);
  endproperty
  a_off_base: assert property (p_off_base)
    else $error("answered outside the base window");

endmodule // des_security_engine

`default_nettype wire

/* logic/des_pkg.sv */
// des_pkg: register map, commands, timing and cipher tables for the block engine
// assumes one 200 MHz clock and a byte-wide register port driven by a host
package des_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 5;                            // ref_clk_i period
  localparam int ALGO_CYCLES   = 320;                          // one block through the algorithm
  localparam int ROUNDS        = 16;                           // cipher rounds per block
  localparam int CYC_PER_ROUND = ALGO_CYCLES / ROUNDS;         // round spacing
  localparam int BYTE_TIME_NS  = 500;                          // longest wait for a result byte
  localparam int BYTE_CYCLES   = BYTE_TIME_NS / CLK_PERIOD_NS; // rounded down; read answers in 1

  // register offsets within the 32-byte window
  localparam logic [4:0] OFS_DATA = 5'h00; // 8 bytes: input block write, result read
  localparam logic [4:0] OFS_KEY  = 5'h08; // 8 bytes: key staging, write only
  localparam logic [4:0] OFS_CTRL = 5'h10; // mode bits
  localparam logic [4:0] OFS_CMD  = 5'h11; // command, write only
  localparam logic [4:0] OFS_STAT = 5'h12; // busy and key parity
  localparam logic [4:0] OFS_INT  = 5'h13; // sticky events, write one to clear
  localparam logic [4:0] OFS_MASK = 5'h14; // event enables
  localparam logic [4:0] OFS_IV   = 5'h18; // 8 bytes: feedback register

  // field positions
  localparam int CTRL_DEC_BIT   = 0; // 1 = decipher
  localparam int CTRL_CFB_BIT   = 1; // 1 = cipher feedback, 0 = block
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_PAR_BIT   = 1;
  localparam int INT_DONE_BIT   = 0; // block or key job finished
  localparam int INT_REFUSE_BIT = 1; // command refused

  // reset values
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [1:0]  MASK_RST = 2'h0;

  // commands
  localparam logic [7:0] CMD_START    = 8'h01; // process one data block
  localparam logic [7:0] CMD_LOAD_ACT = 8'h02; // staged key to active key
  localparam logic [7:0] CMD_LOAD_MAJ = 8'h03; // staged key to major key
  localparam logic [7:0] CMD_UNWRAP   = 8'h04; // decipher staged key into active key
  localparam logic [7:0] CMD_RESTORE  = 8'h05; // major key to active key

  typedef enum logic {ST_IDLE, ST_RUN} eng_state_t;
  typedef enum logic [1:0] {JOB_BLOCK, JOB_CFB_ENC, JOB_CFB_DEC, JOB_UNWRAP} job_t;

  // per-round key rotation: bit set means rotate by one, else by two
  localparam logic [15:0] ROT_ONE_ENC = 16'h8103;
  localparam logic [15:0] ROT_ONE_DEC = 16'h8102;

  // permutation tables, one byte per entry, first entry in the top byte
  localparam logic [511:0] IP_TAB = {256'h3A322A221A120A023C342C241C140C043E362E261E160E064038302820181008,
                                     256'h39312921191109013B332B231B130B033D352D251D150D053F372F271F170F07};
  localparam logic [255:0] P_TAB = 256'h10071415_1D0C1C11_010F171A_05121F0A_0208180E_201B0309_130D1E06_160B0419;
  localparam logic [447:0] PC1_TAB = {224'h39312921191109013A322A221A120A023B332B231B130B033C342C24,
                                      224'h3F372F271F170F073E362E261E160E063D352D251D150D051C140C04};
  localparam logic [383:0] PC2_TAB = {192'h0E110B180105031C0F06150A17130C041A0810071B140D02,
                                      192'h29341F252F371E28332D21302C31273822352E2A32241D20};

  // substitution boxes, 64 nibbles each, row-major
  localparam logic [255:0] SBOX_TAB [8] = '{
    256'hE4D12FB83A6C59070F74E2D1A6CB953841E8D62BFC973A50FC8249175B3EA06D,
    256'hF18E6B34972DC05A3D47F28EC01A69B50E7BA4D158C6932FD8A13F42B67C05E9,
    256'hA09E63F51DC7B428D709346A285ECBF1D6498F30B12C5AE71AD069874FE3B52C,
    256'h7DE3069A1285BC4FD8B56F03472C1AE9A690CB7DF13E52843F06A1D8945BC72E,
    256'h2C417AB6853FD0E9EB2C47D150FA3986421BAD78F9C5630EB8C71E2D6F09A453,
    256'hC1AF92680D34E75BAF427C9561DE0B389EF528C3704A1DB6432C95FABE17608D,
    256'h4B2EF08D3C975A61D0B7491AE35C2F8614BDC37EAF6805926BD814A7950FE23C,
    256'hD2846FB1A93E50C71FD8A374C56B0E927B419CE206ADF35821E74A8DFC90356B};

  // gather n bits by table; bit 1 of the table is the msb of an inw-bit input
  function automatic logic [63:0] permute(input logic [63:0] din, input logic [511:0] tab,
                                          input int n, input int inw);
    logic [63:0] r;
    int          t;
    r = '0;
    for (int i = 0; i < n; i++)
    begin
      t = int'(tab[8 * (n - 1 - i) +: 8]);
      r[n - 1 - i] = din[inw - t];
    end
    return r;
  endfunction

  // undo the initial permutation
  function automatic logic [63:0] ip_inverse(input logic [63:0] din);
    logic [63:0] r;
    int          t;
    r = '0;
    for (int i = 0; i < 64; i++)
    begin
      t = int'(IP_TAB[8 * (63 - i) +: 8]);
      r[64 - t] = din[63 - i];
    end
    return r;
  endfunction

  // byte 0 is the most significant byte
  function automatic logic [7:0] get_byte(input logic [63:0] v, input logic [2:0] idx);
    return v[63 - 8 * idx -: 8];
  endfunction

  function automatic logic [63:0] set_byte(input logic [63:0] v, input logic [2:0] idx,
                                           input logic [7:0] b);
    logic [63:0] r;
    r = v;
    r[63 - 8 * idx -: 8] = b;
    return r;
  endfunction

  // every byte must hold an odd number of ones (lsb is the parity bit)
  function automatic logic odd_parity_ok(input logic [63:0] k);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ok = ok & (^k[63 - 8 * i -: 8]);
    end
    return ok;
  endfunction

endpackage

/* logic/des_round_if.sv */
// des_round_if: links the engine sequencer to its round function
// assumes the engine drives half block and subkey in the same cycle it reads f_out
`timescale 1ns/100ps
`default_nettype none

interface des_round_if;
  logic [31:0] r_half;  // right half entering the round
  logic [47:0] subkey;  // round key
  logic [31:0] f_out;   // cipher function result

  modport engine (output r_half, output subkey, input f_out);
  modport round  (input r_half, input subkey, output f_out);
endinterface // des_round_if

`default_nettype wire

/* logic/des_round.sv */
// des_round: combinational cipher function: expand, key mix, substitute, permute
// assumes inputs are stable flops of the engine; no state of its own
`timescale 1ns/100ps
`default_nettype none

module des_round (
  des_round_if.round rif  // half block and key in, function out
);
  import des_pkg::*;

  logic [47:0] expd;      // expanded half block
  logic [47:0] mixed;     // after key mix
  logic [31:0] sbox_out;  // substitution result
  logic [63:0] perm_out;  // permuted, low 32 bits used

  // expansion: each group of six takes four bits and both neighbours, wrapping
  always_comb
  begin
    expd = '0;
    for (int g = 0; g < 8; g++)
    begin
      for (int j = 0; j < 6; j++)
      begin
        expd[47 - (6 * g + j)] = rif.r_half[(64 - 4 * g - j) % 32];
      end
    end
  end

  assign mixed = expd ^ rif.subkey;

  // eight boxes; outer bits pick the row, inner four the column
  generate
    for (genvar b = 0; b < 8; b++)
    begin : g_sbox
      logic [5:0] six;  // box input
      logic [5:0] sel;  // row then column
      assign six = mixed[47 - 6 * b -: 6];
      assign sel = {six[5], six[0], six[4:1]};
      assign sbox_out[31 - 4 * b -: 4] = SBOX_TAB[b][255 - 4 * sel -: 4];
    end
  endgenerate

  assign perm_out  = permute({32'h0000_0000, sbox_out}, {256'h0, P_TAB}, 32, 32);
  assign rif.f_out = perm_out[31:0];

endmodule // des_round

`default_nettype wire

/* test/des_host_model.sv */
// des_host_model: byte bus master standing in for the host processor
// assumes it runs on the engine clock; one-cycle strobes, no wait states
`timescale 1ns/100ps
`default_nettype none

module des_host_model (
  input  wire logic        ref_clk_i, // engine clock, host locked to it
  output logic      [15:0] addr_o,    // bus address
  output logic      [7:0]  wdata_o,   // write data
  output logic             wr_o,      // write strobe
  output logic             rd_o,      // read strobe
  input  wire logic [7:0]  rdata_i    // read data
);
  // quiet bus at time zero
  initial
  begin
    addr_o  = 16'h0000;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // one write; data flips after release so a stale byte never matches
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask

  // one read; the byte is taken in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    rd_o   <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask
endmodule // des_host_model

`default_nettype wire

/* test/des_security_engine_bench.sv */
// des_security_engine_bench: self-checking bench for the block cipher engine
// assumes des_pkg and des_host_model are compiled first; 200 MHz clock
`timescale 1ns/100ps
`default_nettype none

module des_security_engine_bench;
  import des_pkg::*;

  localparam logic [15:0] BASE = 16'hC000;             // switch setting
  localparam logic [63:0] K1   = 64'h133457799BBCDFF1; // good parity
  localparam logic [63:0] K2   = 64'h0E329232EA6D0D73; // good parity
  localparam logic [63:0] PT   = 64'h0123456789ABCDEF; // plain block
  localparam logic [63:0] CT   = 64'h85E813540F0AB405; // PT under K1

  typedef struct packed {logic [63:0] key; logic [1:0] ctrl; logic [63:0] iv;
                         logic [63:0] din; logic [63:0] dout; logic [63:0] iv_out;} row_t;

  logic        ref_clk = 1'b0; // engine clock
  logic        rst_n   = 1'b0; // sync reset
  logic [15:0] sw      = BASE; // base switches
  logic [15:0] addr;           // host address
  logic [7:0]  wdata;          // host data
  logic        wr;             // write strobe
  logic        rd;             // read strobe
  logic [7:0]  rdata;          // read data
  logic        irq;            // interrupt
  logic        busy;           // engine running
  logic        par_ok;         // key parity flag
  logic [7:0]  b;              // scratch byte
  logic [63:0] v;              // scratch block
  int          n;              // busy count
  int          num_errors = 0; // mismatches
  int          cmp_count  = 0; // comparisons
  // block, decipher, block, feedback encipher, feedback decipher
  row_t rows [5] = '{'{K1, 2'h0, 64'h0, PT, CT, 64'h0}, '{K1, 2'h1, 64'h0, CT, PT, 64'h0},
    '{K2, 2'h0, 64'h0, 64'h8787878787878787, 64'h0, 64'h0}, '{K1, 2'h2, PT, 64'h0, CT, CT},
    '{K1, 2'h3, PT, CT, 64'h0, CT}};

  // 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  des_security_engine u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .base_sw_i(sw), .rdata_o(rdata), .irq_o(irq), .busy_o(busy),
    .key_par_ok_o(par_ok));
  des_host_model u_host (.ref_clk_i(ref_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));

  // verdict and stop
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // count and report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] adr(input logic [4:0] ofs);
    return {sw[15:5], ofs};
  endfunction

  // eight bytes, most significant first
  task automatic put8(input logic [4:0] ofs, input logic [63:0] d);
    for (int i = 0; i < 8; i++)
      u_host.wr(adr(ofs + 5'(i)), d[63 - 8 * i -: 8]);
  endtask

  task automatic get8(input logic [4:0] ofs, output logic [63:0] d);
    for (int i = 0; i < 8; i++)
    begin
      u_host.rd(adr(ofs + 5'(i)), b);
      d[63 - 8 * i -: 8] = b;
    end
  endtask

  task automatic rchk(input logic [4:0] ofs, input logic [7:0] exp);
    u_host.rd(adr(ofs), b);
    chk(64'(b), 64'(exp));
  endtask

  // poll busy, bounded; a hang ends the run
  task automatic wait_idle();
    n = 0;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge ref_clk);
      if (busy !== 1'b1)
        break;
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      end_of_test();
    end
  endtask

  // command, busy window, done flag, clear
  task automatic run_job(input logic [7:0] cmd, input logic irq_exp);
    u_host.wr(adr(OFS_CMD), cmd);
    wait_idle();
    chk(64'(n), 64'(ALGO_CYCLES));
    chk(64'(irq), 64'(irq_exp));
    rchk(OFS_INT, 8'h01);
    u_host.wr(adr(OFS_INT), 8'h01);
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    chk(64'({rdata, irq, busy, par_ok}), 64'h0);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rchk(OFS_STAT, 8'h00);
    rchk(OFS_MASK, 8'h00);
    // table rows, interrupt masked
    foreach (rows[r])
    begin
      put8(OFS_KEY, rows[r].key);
      u_host.wr(adr(OFS_CMD), CMD_LOAD_ACT);
      put8(OFS_IV, rows[r].iv);
      put8(OFS_DATA, rows[r].din);
      u_host.wr(adr(OFS_CTRL), 8'(rows[r].ctrl));
      chk(64'(par_ok), 64'h1);
      run_job(CMD_START, 1'b0);
      get8(OFS_DATA, v);
      chk(v, rows[r].dout);
      get8(OFS_IV, v);
      chk(v, rows[r].iv_out);
    end
    // command while busy is refused, interrupt on done
    u_host.wr(adr(OFS_MASK), 8'h01);
    u_host.wr(adr(OFS_CTRL), 8'h00);
    put8(OFS_DATA, PT);
    u_host.wr(adr(OFS_CMD), CMD_START);
    u_host.wr(adr(OFS_CMD), CMD_RESTORE);
    rchk(OFS_STAT, 8'h03);
    wait_idle();
    chk(64'(irq), 64'h1);
    get8(OFS_DATA, v);
    chk(v, CT);
    rchk(OFS_INT, 8'h03);
    u_host.wr(adr(OFS_INT), 8'h03);
    repeat (2) @(negedge ref_clk);
    chk(64'(irq), 64'h0);
    // unknown codes, refusal bit is masked off
    foreach (rows[r])
    begin
      u_host.wr(adr(OFS_CMD), 8'h06 + 8'(r * 40));
      rchk(OFS_INT, 8'h02);
      chk(64'(irq), 64'h0);
      u_host.wr(adr(OFS_INT), 8'h02);
    end
    // major key, restore, unwrap
    put8(OFS_KEY, K2);
    u_host.wr(adr(OFS_CMD), CMD_LOAD_MAJ);
    u_host.wr(adr(OFS_CMD), CMD_RESTORE);
    put8(OFS_DATA, 64'h8787878787878787);
    run_job(CMD_START, 1'b1);
    get8(OFS_DATA, v);
    chk(v, 64'h0);
    put8(OFS_KEY, 64'h0);
    run_job(CMD_UNWRAP, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk(64'(par_ok), 64'h0);
    rchk(OFS_STAT, 8'h00);
    put8(OFS_KEY, K1);
    u_host.wr(adr(OFS_CMD), CMD_LOAD_MAJ);
    repeat (3) @(negedge ref_clk);
    chk(64'(par_ok), 64'h0);
    u_host.wr(adr(OFS_CMD), CMD_RESTORE);
    repeat (3) @(negedge ref_clk);
    chk(64'(par_ok), 64'h1);
    put8(OFS_DATA, PT);
    run_job(CMD_START, 1'b1);
    get8(OFS_DATA, v);
    chk(v, CT);
    // off-base, unmapped and write-only places
    u_host.wr(16'h0010, 8'h03);
    rchk(OFS_CTRL, 8'h00);
    u_host.rd(16'h0000, b);
    chk(64'(b), 64'h0);
    rchk(5'h15, 8'h00);
    rchk(OFS_KEY, 8'h00);
    // move the window; low switch bits are ignored
    @(posedge ref_clk);
    sw <= 16'hA01F;
    repeat (5) @(posedge ref_clk);
    rchk(OFS_MASK, 8'h01);
    u_host.rd({BASE[15:5], OFS_MASK}, b);
    chk(64'(b), 64'h0);
    // reset in mid-run
    u_host.wr(adr(OFS_CMD), CMD_START);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(64'({irq, busy, par_ok}), 64'h0);
    // release again; mask must come back cleared
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rchk(OFS_MASK, 8'h00);
    end_of_test();
  end
endmodule // des_security_engine_bench

`default_nettype wire
